// ### rtl/cmt_pkg.sv
// Package: register map, field layouts and types of the cycle/macrotick timers
package cmt_pkg;
  localparam logic [7:0]  OFS_TIMER_CONFIG_CONTROL  = 8'h00;
  localparam logic [7:0]  OFS_TIMER_ONE_CYCLE_SETUP = 8'h04;
  localparam logic [7:0]  OFS_TIMER_ONE_MT_VALUE    = 8'h08;
  localparam logic [7:0]  OFS_TIMER_TWO_CONFIG_LOW  = 8'h0c;
  localparam logic [7:0]  OFS_TIMER_TWO_CONFIG_HIGH = 8'h10;
  localparam logic [7:0]  OFS_IRQ_STATUS            = 8'h14;
  localparam logic [7:0]  OFS_IRQ_CLEAR             = 8'h18;
  localparam logic [7:0]  OFS_IRQ_ENABLE            = 8'h1c;

  // timer_config_control fields
  localparam int BIT_T1_TRIGGER  = 0;
  localparam int BIT_T1_STOP     = 1;
  localparam int BIT_T1_REPEAT   = 2;
  localparam int BIT_T2_TRIGGER  = 3;
  localparam int BIT_T2_STOP     = 4;
  localparam int BIT_T2_REPEAT   = 5;
  localparam int BIT_T2_RELATIVE = 6;
  localparam int BIT_T1_RUNNING  = 8;
  localparam int BIT_T2_RUNNING  = 9;
  // Cycle setup: value in [5:0], mask in [13:8]
  localparam int CYC_VAL_LSB = 0;
  localparam int CYC_MSK_LSB = 8;
  localparam int CYC_W       = 6;
  localparam int MT_W        = 16;
  // Interrupt layout
  localparam int IRQ_T1 = 0;
  localparam int IRQ_T2 = 1;
  localparam int IRQ_W  = 2;

  localparam logic [31:0] RST_WORD = 32'h0000_0000;

  typedef struct packed {
    logic [CYC_W-1:0] cyc_mask;
    logic [CYC_W-1:0] cyc_value;
    logic [MT_W-1:0]  mt_value;
  } cmt_abs_cfg_s;

  typedef struct packed {
    logic             mt_start;
    logic [CYC_W-1:0] cycle;
    logic [MT_W-1:0]  macrotick;
    logic             normal;
  } cmt_time_s;
endpackage : cmt_pkg

// ### rtl/cmt_timer.sv
// One timer channel: absolute match or relative 32-bit down counter
module cmt_timer (
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire cmt_pkg::cmt_time_s   tb,
  input  wire cmt_pkg::cmt_abs_cfg_s cfg,
  input  wire logic                 relative,
  input  wire logic [31:0]          rel_amount,
  input  wire logic                 repeat_mode,
  input  wire logic                 trigger,
  input  wire logic                 stop,
  output logic                      running,
  output logic                      expire
);
  logic        next_running;
  logic [31:0] down;
  logic [31:0] next_down;
  logic        hit;

  always_comb begin
    next_running = running;
    next_down    = down;
    hit          = 1'b0;
    if (relative) begin
      hit = (down == 32'h0000_0000);
    end else begin
      hit = (((tb.cycle ^ cfg.cyc_value) & cfg.cyc_mask) == '0)
            && (tb.macrotick == cfg.mt_value);
    end
    hit = hit && running && tb.mt_start && tb.normal;
    if (running && tb.mt_start && relative) begin
      next_down = down - 32'h0000_0001;
    end
    if (hit) begin
      next_running = repeat_mode;
      next_down    = rel_amount;  // restart counts from reload
    end
    if (trigger) begin
      next_running = 1'b1;
      next_down    = rel_amount;
    end
    if (stop || !tb.normal) begin
      next_running = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      running <= 1'b0;
      down    <= 32'h0000_0000;
      expire  <= 1'b0;
    end else begin
      running <= next_running;
      down    <= next_down;
      expire  <= hit;
    end
  end
endmodule // cmt_timer

// ### rtl/cmt_timers.sv
// Top: two protocol-time-base timers with register port and interrupt
module cmt_timers (
  input  wire logic        MCLK,
  input  wire logic        RESET,
  input  wire logic [7:0]  ADDR,
  input  wire logic [31:0] WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic      [31:0] RDATA,
  input  wire logic        MT_START,
  input  wire logic [5:0]  CYCLE_COUNT,
  input  wire logic [15:0] MACROTICK_COUNT,
  input  wire logic        PROTOCOL_NORMAL,
  output logic             IRQ
);
  // Time base comes from the protocol engine on the same clock
  cmt_pkg::cmt_time_s tb;
  assign tb = '{mt_start: MT_START, cycle: CYCLE_COUNT, macrotick: MACROTICK_COUNT,
                normal: PROTOCOL_NORMAL};

  logic [31:0] timer_config_control;
  logic [31:0] timer_one_cycle_setup;
  logic [31:0] timer_one_mt;
  logic [31:0] timer_two_config_low;
  logic [31:0] timer_two_config_high;
  logic [cmt_pkg::IRQ_W-1:0] protocol_irq_flags_zero;
  logic [cmt_pkg::IRQ_W-1:0] protocol_irq_enables_zero;
  logic [31:0] next_timer_config_control;
  logic [31:0] next_timer_one_cycle_setup;
  logic [31:0] next_timer_one_mt;
  logic [31:0] next_timer_two_config_low;
  logic [31:0] next_timer_two_config_high;
  logic [cmt_pkg::IRQ_W-1:0] next_flags;
  logic [cmt_pkg::IRQ_W-1:0] next_enables;
  logic [31:0] next_rdata;

  logic [cmt_pkg::IRQ_W-1:0] expire;
  logic [cmt_pkg::IRQ_W-1:0] running;
  logic [cmt_pkg::IRQ_W-1:0] trig;
  logic [cmt_pkg::IRQ_W-1:0] stop;
  logic [cmt_pkg::IRQ_W-1:0] rep;
  cmt_pkg::cmt_abs_cfg_s     cfg [cmt_pkg::IRQ_W];
  logic [31:0]               rel_amount;
  logic                      timer_two_relative_select;

  function automatic logic hit_addr(input logic [7:0] a, input logic [7:0] ofs);
    hit_addr = (a == ofs);
  endfunction

  wire logic wr_ctl = WR && hit_addr(ADDR, cmt_pkg::OFS_TIMER_CONFIG_CONTROL);

  // Trigger and stop are self-clearing strobes written into the control word
  assign trig[0] = wr_ctl && WDATA[cmt_pkg::BIT_T1_TRIGGER];
  assign stop[0] = wr_ctl && WDATA[cmt_pkg::BIT_T1_STOP];
  assign trig[1] = wr_ctl && WDATA[cmt_pkg::BIT_T2_TRIGGER];
  assign stop[1] = wr_ctl && WDATA[cmt_pkg::BIT_T2_STOP];
  assign rep[0]  = timer_config_control[cmt_pkg::BIT_T1_REPEAT];
  assign rep[1]  = timer_config_control[cmt_pkg::BIT_T2_REPEAT];
  assign timer_two_relative_select = timer_config_control[cmt_pkg::BIT_T2_RELATIVE];

  assign cfg[0] = '{cyc_mask: timer_one_cycle_setup[cmt_pkg::CYC_MSK_LSB +: cmt_pkg::CYC_W],
                    cyc_value: timer_one_cycle_setup[cmt_pkg::CYC_VAL_LSB +: cmt_pkg::CYC_W],
                    mt_value: timer_one_mt[cmt_pkg::MT_W-1:0]};
  // Absolute timer two: cycle setup in low word, macrotick in high word
  assign cfg[1] = '{cyc_mask: timer_two_config_low[cmt_pkg::CYC_MSK_LSB +: cmt_pkg::CYC_W],
                    cyc_value: timer_two_config_low[cmt_pkg::CYC_VAL_LSB +: cmt_pkg::CYC_W],
                    mt_value: timer_two_config_high[cmt_pkg::MT_W-1:0]};
  assign rel_amount = {timer_two_config_high[15:0], timer_two_config_low[15:0]};

  genvar g;
  generate
    for (g = 0; g < cmt_pkg::IRQ_W; g++) begin : g_tmr
      cmt_timer cmt_timer_i (
        .clk        (MCLK),
        .rst        (RESET),
        .tb         (tb),
        .cfg        (cfg[g]),
        .relative   ((g == 1) ? timer_two_relative_select : 1'b0),
        .rel_amount (rel_amount),
        .repeat_mode(rep[g]),
        .trigger    (trig[g]),
        .stop       (stop[g]),
        .running    (running[g]),
        .expire     (expire[g])
      );
    end
  endgenerate

  // Per-register write selects; control select stays above for the strobes
  // Each register group below has its own next-value and register process
  logic wr_t1_setup;
  logic wr_t1_mt;
  logic wr_t2_low;
  logic wr_t2_high;
  logic wr_clear;
  logic wr_enable;

  assign wr_t1_setup = WR && hit_addr(ADDR, cmt_pkg::OFS_TIMER_ONE_CYCLE_SETUP);
  assign wr_t1_mt    = WR && hit_addr(ADDR, cmt_pkg::OFS_TIMER_ONE_MT_VALUE);
  assign wr_t2_low   = WR && hit_addr(ADDR, cmt_pkg::OFS_TIMER_TWO_CONFIG_LOW);
  assign wr_t2_high  = WR && hit_addr(ADDR, cmt_pkg::OFS_TIMER_TWO_CONFIG_HIGH);
  assign wr_clear    = WR && hit_addr(ADDR, cmt_pkg::OFS_IRQ_CLEAR);
  assign wr_enable   = WR && hit_addr(ADDR, cmt_pkg::OFS_IRQ_ENABLE);

  // Configuration words hold 16 bits; upper bits read back as zero
  function automatic logic [31:0] low_half(input logic [31:0] d);
    low_half = {16'h0000, d[15:0]};
  endfunction

  // Status and enable words share one zero-extended layout
  function automatic logic [31:0] irq_word(input logic [cmt_pkg::IRQ_W-1:0] bits);
    irq_word                     = cmt_pkg::RST_WORD;
    irq_word[cmt_pkg::IRQ_W-1:0] = bits;
  endfunction

  // Only mode bits are stored; trigger and stop act as one-cycle strobes
  always_comb begin
    next_timer_config_control = timer_config_control;
    if (wr_ctl) begin
      next_timer_config_control                           = cmt_pkg::RST_WORD;
      next_timer_config_control[cmt_pkg::BIT_T1_REPEAT]   = WDATA[cmt_pkg::BIT_T1_REPEAT];
      next_timer_config_control[cmt_pkg::BIT_T2_REPEAT]   = WDATA[cmt_pkg::BIT_T2_REPEAT];
      next_timer_config_control[cmt_pkg::BIT_T2_RELATIVE] = WDATA[cmt_pkg::BIT_T2_RELATIVE];
    end
  end

  // Mode bits survive an expiry; only a new control write changes them
  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      timer_config_control <= cmt_pkg::RST_WORD;
    end else begin
      timer_config_control <= next_timer_config_control;
    end
  end

  // Cycle setup keeps value and mask fields only
  always_comb begin
    next_timer_one_cycle_setup = timer_one_cycle_setup;
    if (wr_t1_setup) begin
      next_timer_one_cycle_setup = WDATA & 32'h0000_3f3f;
    end
  end

  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      timer_one_cycle_setup <= cmt_pkg::RST_WORD;
    end else begin
      timer_one_cycle_setup <= next_timer_one_cycle_setup;
    end
  end

  // Timer one macrotick match value
  always_comb begin
    next_timer_one_mt = timer_one_mt;
    if (wr_t1_mt) begin
      next_timer_one_mt = low_half(WDATA);
    end
  end

  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      timer_one_mt <= cmt_pkg::RST_WORD;
    end else begin
      timer_one_mt <= next_timer_one_mt;
    end
  end

  // Timer two low word: cycle setup or low half of relative amount
  always_comb begin
    next_timer_two_config_low = timer_two_config_low;
    if (wr_t2_low) begin
      next_timer_two_config_low = low_half(WDATA);
    end
  end

  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      timer_two_config_low <= cmt_pkg::RST_WORD;
    end else begin
      timer_two_config_low <= next_timer_two_config_low;
    end
  end

  // Timer two high word: macrotick or high half of relative amount
  always_comb begin
    next_timer_two_config_high = timer_two_config_high;
    if (wr_t2_high) begin
      next_timer_two_config_high = low_half(WDATA);
    end
  end

  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      timer_two_config_high <= cmt_pkg::RST_WORD;
    end else begin
      timer_two_config_high <= next_timer_two_config_high;
    end
  end

  // An expiry in the clear cycle wins, so no timer event is lost
  always_comb begin
    next_flags = protocol_irq_flags_zero;
    if (wr_clear) begin
      next_flags = next_flags & ~WDATA[cmt_pkg::IRQ_W-1:0];
    end
    next_flags = next_flags | expire;
  end

  // Flags are sticky until software clears them
  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      protocol_irq_flags_zero <= '0;
    end else begin
      protocol_irq_flags_zero <= next_flags;
    end
  end

  // Enables mask only the request, never the flags
  always_comb begin
    next_enables = protocol_irq_enables_zero;
    if (wr_enable) begin
      next_enables = WDATA[cmt_pkg::IRQ_W-1:0];
    end
  end

  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      protocol_irq_enables_zero <= '0;
    end else begin
      protocol_irq_enables_zero <= next_enables;
    end
  end

  // Running bits are live; strobe bits always read back as zero
  logic [31:0] ctl_view;
  always_comb begin
    ctl_view                          = timer_config_control;
    ctl_view[cmt_pkg::BIT_T1_RUNNING] = running[0];
    ctl_view[cmt_pkg::BIT_T2_RUNNING] = running[1];
  end

  // Read data stand for one cycle only, zero otherwise
  always_comb begin
    next_rdata = cmt_pkg::RST_WORD;
    if (RD) begin
      case (ADDR)
        cmt_pkg::OFS_TIMER_CONFIG_CONTROL: begin
          next_rdata = ctl_view;
        end
        cmt_pkg::OFS_TIMER_ONE_CYCLE_SETUP: begin
          next_rdata = timer_one_cycle_setup;
        end
        cmt_pkg::OFS_TIMER_ONE_MT_VALUE: begin
          next_rdata = timer_one_mt;
        end
        cmt_pkg::OFS_TIMER_TWO_CONFIG_LOW: begin
          next_rdata = timer_two_config_low;
        end
        cmt_pkg::OFS_TIMER_TWO_CONFIG_HIGH: begin
          next_rdata = timer_two_config_high;
        end
        cmt_pkg::OFS_IRQ_STATUS: begin
          next_rdata = irq_word(protocol_irq_flags_zero);
        end
        cmt_pkg::OFS_IRQ_ENABLE: begin
          next_rdata = irq_word(protocol_irq_enables_zero);
        end
        default: begin
          next_rdata = cmt_pkg::RST_WORD;
        end
      endcase
    end
  end

  // Registered read port; the clear register reads as zero
  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      RDATA <= cmt_pkg::RST_WORD;
    end else begin
      RDATA <= next_rdata;
    end
  end

  // Each timer gated by its own enable
  logic [cmt_pkg::IRQ_W-1:0] irq_pending;
  assign irq_pending = protocol_irq_flags_zero & protocol_irq_enables_zero;
  assign IRQ         = |irq_pending;

endmodule // cmt_timers

// ### verification/cmt_timers_checker.sv
// Checker: port-level assertions for the cycle/macrotick timers
module cmt_timers_checker (
  input wire logic        MCLK,
  input wire logic        RESET,
  input wire logic [7:0]  ADDR,
  input wire logic [31:0] WDATA,
  input wire logic        WR,
  input wire logic        RD,
  input wire logic [31:0] RDATA,
  input wire logic        MT_START,
  input wire logic        PROTOCOL_NORMAL,
  input wire logic        IRQ
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RESET);
  sequence stop_both;
    WR && ADDR == 8'h00 && WDATA[1] && WDATA[4];
  endsequence
  sequence read_ctrl;
    RD && ADDR == 8'h00;
  endsequence
  a_rdata_quiet: assert property (!RD |=> RDATA == 32'h0)
    else $error("read data not zero outside answer cycle");
  a_irq_cause: assert property ($rose(IRQ) |-> $past(WR) || ($past(MT_START, 2) && $past(PROTOCOL_NORMAL, 2)))
    else $error("interrupt rose without macrotick start or write");
  a_irq_sticky: assert property ($fell(IRQ) |-> $past(WR))
    else $error("interrupt fell without software write");
  a_clear_drops: assert property (WR && ADDR == 8'h18 && WDATA[1:0] == 2'b11 && !$past(MT_START) |=> !IRQ)
    else $error("interrupt kept after clearing all flags");
  a_enable_off: assert property (WR && ADDR == 8'h1c && WDATA[1:0] == 2'b00 |=> !IRQ)
    else $error("interrupt kept with all enables off");
  a_halt_outside: assert property (!PROTOCOL_NORMAL && !WR ##1 read_ctrl |=> RDATA[9:8] == 2'b00)
    else $error("timer running outside normal state");
  a_stop_clears: assert property (stop_both ##1 !WR ##1 read_ctrl |=> RDATA[9:8] == 2'b00)
    else $error("running bit kept after stop");
  a_strobe_zero: assert property (read_ctrl |=> RDATA[1:0] == 2'b00 && RDATA[4:3] == 2'b00)
    else $error("trigger or stop strobe read back");
  a_unmapped_zero: assert property (RD && (ADDR == 8'h18 || ADDR > 8'h1c) |=> RDATA == 32'h0)
    else $error("write-only or unmapped place read nonzero");
endmodule // cmt_timers_checker

bind cmt_timers cmt_timers_checker cmt_timers_checker_i (.MCLK(MCLK), .RESET(RESET), .ADDR(ADDR),
  .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .MT_START(MT_START), .PROTOCOL_NORMAL(PROTOCOL_NORMAL), .IRQ(IRQ));

// ### verification/cmt_timers_tb.sv
// Testbench: register-driven scenarios for the cycle/macrotick timers
module cmt_timers_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        MCLK = 0, RESET = 1, WR = 0, RD = 0, MT_START = 0, PROTOCOL_NORMAL = 1, IRQ, rd_d = 0;
  logic [7:0]  ADDR = 0;
  logic [31:0] WDATA = 0, RDATA, v, exp_q[$], msk_q[$];
  logic [5:0]  CYCLE_COUNT = 0, m;
  logic [15:0] MACROTICK_COUNT = 0;
  logic [31:0] n_tab[3] = '{32'h0, 32'h1, 32'h4};
  int          fails = 0, checked = 0;
  always #2.5 MCLK = ~MCLK;
  cmt_timers cmt_timers_i (.MCLK(MCLK), .RESET(RESET), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .MT_START(MT_START), .CYCLE_COUNT(CYCLE_COUNT), .MACROTICK_COUNT(MACROTICK_COUNT),
    .PROTOCOL_NORMAL(PROTOCOL_NORMAL), .IRQ(IRQ));
  task automatic check(logic [31:0] seen, logic [31:0] want);
    checked++;
    if (seen !== want) begin
      fails++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, want);
    end
  endtask
  task automatic test_done();
    if (fails == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge MCLK);
    WR <= 1;
    ADDR <= a;
    WDATA <= d;
    @(posedge MCLK);
    WR <= 0;
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] e, logic [31:0] mk = 32'hffffffff);
    @(posedge MCLK);
    RD <= 1;
    ADDR <= a;
    exp_q.push_back(e);
    msk_q.push_back(mk);
    @(posedge MCLK);
    RD <= 0;
  endtask
  // Flags land two edges after a pulse, so each pulse leaves room for that
  task automatic tick(int n);
    repeat (n) begin
      @(posedge MCLK);
      MT_START <= 1;
      @(posedge MCLK);
      MT_START <= 0;
      MACROTICK_COUNT <= MACROTICK_COUNT + 16'h1;
      @(posedge MCLK);
    end
    @(posedge MCLK);
  endtask
  task automatic irq(logic e);
    @(negedge MCLK);
    check({31'h0, IRQ}, {31'h0, e});
    @(posedge MCLK);
  endtask
  // Read data stand only in the cycle after the strobe
  always @(negedge MCLK) begin
    if (rd_d) check(RDATA & msk_q.pop_front(), exp_q.pop_front());
    rd_d = RD;
  end
  initial begin
    repeat (4000) @(posedge MCLK);
    fails++;
    test_done();
  end
  initial begin
    void'($urandom(32'h9ff278b7));
    repeat (20) @(posedge MCLK);
    RESET <= 0;
    rd(8'h00, 0);
    rd(8'h20, 0);
    rd(8'h18, 0);
    wr(8'h1c, 3);
    rd(8'h1c, 3);
    m = 6'($urandom) | 6'h01;
    v = $urandom;
    wr(8'h04, {18'h0, m, 2'h0, v[5:0]});
    wr(8'h08, 5);
    CYCLE_COUNT <= v[5:0] ^ m;
    MACROTICK_COUNT <= 0;
    wr(8'h00, 32'h1);
    rd(8'h00, 32'h100, 32'h300);
    tick(8);
    irq(0);
    CYCLE_COUNT <= v[5:0] ^ ~m;
    MACROTICK_COUNT <= 0;
    tick(5);
    irq(0);
    tick(1);
    irq(1);
    rd(8'h14, 1);
    rd(8'h00, 0, 32'h300);
    wr(8'h18, 3);
    irq(0);
    MACROTICK_COUNT <= 0;
    wr(8'h00, 32'h5);
    tick(6);
    rd(8'h00, 32'h100, 32'h300);
    wr(8'h18, 3);
    MACROTICK_COUNT <= 0;
    tick(6);
    irq(1);
    PROTOCOL_NORMAL <= 0;
    rd(8'h00, 0, 32'h300);
    wr(8'h18, 3);
    PROTOCOL_NORMAL <= 1;
    MACROTICK_COUNT <= 0;
    tick(6);
    irq(0);
    wr(8'h00, 32'h5);
    wr(8'h00, 32'h12);
    rd(8'h00, 0, 32'h300);
    foreach (n_tab[i]) begin
      wr(8'h0c, n_tab[i]);
      wr(8'h10, 0);
      wr(8'h00, 32'h48);
      tick(n_tab[i]);
      rd(8'h14, 0);
      tick(1);
      rd(8'h14, 2);
      rd(8'h00, 0, 32'h300);
      wr(8'h18, 3);
    end
    wr(8'h1c, 1);
    wr(8'h0c, {18'h0, m, 2'h0, v[5:0]});
    wr(8'h10, 3);
    MACROTICK_COUNT <= 0;
    wr(8'h00, 32'h8);
    tick(4);
    rd(8'h14, 2);
    irq(0);
    wr(8'h1c, 2);
    irq(1);
    wr(8'h1c, 0);
    irq(0);
    repeat (3) @(posedge MCLK);
    test_done();
  end
endmodule // cmt_timers_tb
